// ---- rtl/cbp_top.sv ----
/*
  cbp_top: power-up sequencer, strap capture, pll mode control
  and output gating of a 12-output differential clock buffer.
  assumes: reference clock, power good, supply good, pll lock
  and straps are asynchronous pins; software uses Avalon-MM.
*/
// The register addresses and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module cbp_top
  import cbp_pkg::*;
(
  input  wire logic               sys_clk_in,
  input  wire logic               rst_n_in,
  input  wire logic               ref_clk_in,
  input  wire logic               supply_good_in,
  input  wire logic               power_good_in,
  input  wire logic               pll_lock_in,
  input  wire logic               freq_select_strap_in,
  input  wire logic [1:0]         addr_strap_low_in,
  input  wire logic [1:0]         addr_strap_high_in,
  input  wire logic [1:0]         pll_bandwidth_strap_in,
  input  wire logic [3:0]         avs_address_in,
  input  wire logic               avs_read_in,
  input  wire logic               avs_write_in,
  input  wire logic [31:0]        avs_writedata_in,
  input  wire logic [3:0]         avs_byteenable_in,
  output logic [31:0]             avs_readdata_out,
  output logic                    avs_waitrequest_out,
  output logic [NUM_OUT-1:0]      diff_clock_out,
  output logic [NUM_OUT-1:0]      diff_clock_n_out,
  output logic                    osc_enable_out,
  output logic                    pll_bypass_out,
  output logic                    pll_wide_band_out,
  output logic                    pll_narrow_band_out,
  output logic                    freq_100m_out,
  output logic [7:0]              smbus_addr_out,
  output logic                    smbus_scl_oe_n_out,
  output logic                    smbus_sda_oe_n_out
);

  // ===========================================================
  // helper functions

  // strap pair to 8-bit bus address, low-low first
  function automatic logic [7:0] addr_decode(
    input logic [1:0] hi,
    input logic [1:0] lo
  );
    logic [3:0] idx;
    idx = 4'h0;
    idx = ((hi == TRI_LOW) ? 4'h0 : (hi == TRI_MID) ? 4'h3 : 4'h6)
        + ((lo == TRI_LOW) ? 4'h0 : (lo == TRI_MID) ? 4'h1 : 4'h2);
    case (idx)
      4'h0: addr_decode = 8'hd8;
      4'h1: addr_decode = 8'hda;
      4'h2: addr_decode = 8'hde;
      4'h3: addr_decode = 8'hc2;
      4'h4: addr_decode = 8'hc4;
      4'h5: addr_decode = 8'hc6;
      4'h6: addr_decode = 8'hca;
      4'h7: addr_decode = 8'hcc;
      default: addr_decode = 8'hce;
    endcase
  endfunction

  // tri-level strap to readback mode code
  function automatic logic [1:0] mode_of_strap(input logic [1:0] s);
    mode_of_strap = (s == TRI_LOW) ? MODE_NARROW :
                    (s == TRI_MID) ? MODE_BYPASS : MODE_WIDE;
  endfunction

  // three-flop agreement filter: take the level once q2 and q3 agree
  function automatic logic [10:0] agree(
    input logic [10:0] q2,
    input logic [10:0] q3,
    input logic [10:0] lvl
  );
    agree = (q2 & q3) | (lvl & (q2 | q3));
  endfunction

  // ===========================================================
  // input synchronisers
  // bit map: 10 ref, 9 supply, 8 pgood, 7 lock, 6 freq,
  // 5:4 addr high, 3:2 addr low, 1:0 bandwidth strap
  logic [10:0] sync_q1_r;
  logic [10:0] sync_q2_r;
  logic [10:0] sync_q3_r;
  logic [10:0] lvl_r;
  wire  [10:0] raw_in = {ref_clk_in, supply_good_in, power_good_in,
                         pll_lock_in, freq_select_strap_in,
                         addr_strap_high_in, addr_strap_low_in,
                         pll_bandwidth_strap_in};
  wire  [10:0] lvl_nxt = agree(sync_q2_r, sync_q3_r, lvl_r);

  // q1 feeds only q2; lvl moves only on q2/q3 agreement
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      sync_q1_r <= 11'h000;
      sync_q2_r <= 11'h000;
      sync_q3_r <= 11'h000;
      lvl_r     <= 11'h000;
    end else begin
      sync_q1_r <= raw_in;
      sync_q2_r <= sync_q1_r;
      sync_q3_r <= sync_q2_r;
      lvl_r     <= lvl_nxt;
    end
  end

  wire ref_lvl   = lvl_r[10];
  wire supply_ok = lvl_r[9];
  wire pgood     = lvl_r[8];
  wire locked    = lvl_r[7];
  // reference edges; the complement output moves the other way
  wire ref_rise  = lvl_nxt[10] & ~ref_lvl;
  wire ref_fall  = ~lvl_nxt[10] & ref_lvl;
  wire comp_rise = ref_fall;
  wire comp_fall = ref_rise;

  // ===========================================================
  // reference clock presence
  logic [5:0] ref_idle_r;
  logic       ref_valid_r;
  wire        ref_edge = ref_rise | ref_fall;

  // reference counts as missing after a timeout with no edge
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      ref_idle_r  <= 6'h00;
      ref_valid_r <= 1'b0;
    end else if (ref_edge) begin
      ref_idle_r  <= 6'h00;
      ref_valid_r <= 1'b1;
    end else if (ref_idle_r == REF_TIMEOUT_CNT) begin
      ref_valid_r <= 1'b0;
    end else begin
      ref_idle_r  <= ref_idle_r + 6'h01;
    end
  end

  // ===========================================================
  // strap capture on the first rise of power good
  logic       pg_seen_r;
  logic       pg_prev_r;
  logic       freq_lat_r;
  logic [1:0] mode_lat_r;
  logic [7:0] addr_lat_r;
  wire        pg_first_rise = pgood & ~pg_prev_r & ~pg_seen_r;

  // straps are latched once; later pg pulses are power-down only
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      pg_seen_r  <= 1'b0;
      pg_prev_r  <= 1'b0;
      freq_lat_r <= 1'b0;
      mode_lat_r <= MODE_NARROW;
      addr_lat_r <= 8'h00;
    end else begin
      pg_prev_r <= pgood;
      if (pg_first_rise) begin
        pg_seen_r  <= 1'b1;
        freq_lat_r <= lvl_r[6];
        mode_lat_r <= mode_of_strap(lvl_r[1:0]);
        addr_lat_r <= addr_decode(lvl_r[5:4], lvl_r[3:2]);
      end
    end
  end

  // ===========================================================
  // control byte 0 software fields
  logic [1:0] sw_mode_r;
  logic       sw_en_r;
  logic       ack_r;
  wire        wr_take = avs_write_in & ack_r;
  wire        rd_take = avs_read_in & ~ack_r;
  wire        sel_c0  = (avs_address_in == REG_CTRL0);

  // kept across power down; only reset reloads them (mode 2'h3, enable off)
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      sw_mode_r <= C0_SWM_RST;
      sw_en_r   <= C0_SWEN_RST;
    end else if (wr_take && sel_c0 && avs_byteenable_in[0]) begin
      sw_mode_r <= avs_writedata_in[C0_SWM_LO +: 2];
      sw_en_r   <= avs_writedata_in[C0_SWEN];
    end
  end

  // software code 2'h2 is not defined; it is taken as wide band
  // applied at once; the host owes a warm reset before relying on it
  wire [1:0] sw_mode  = (sw_mode_r == 2'h2) ? MODE_WIDE : sw_mode_r;
  wire [1:0] eff_mode = sw_en_r ? sw_mode : mode_lat_r;

  // ===========================================================
  // power sequencer
  cbp_state_e     state_r;
  cbp_state_e     state_nxt;
  logic [CNT_W-1:0] dly_r;
  logic [1:0]     pd_cnt_r;
  wire            pd_req    = pg_seen_r & ~pgood;
  wire            dly_done  = (dly_r == SEQ_DELAY_CNT);
  wire            can_start = ref_valid_r & pg_seen_r & pgood;

  // sequencing decisions
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_OFF: begin
        if (supply_ok) state_nxt = ST_DELAY;
      end
      ST_DELAY: begin
        if (dly_done) state_nxt = ST_WAIT;
      end
      ST_WAIT: begin
        if (can_start && locked) state_nxt = ST_RUN;
      end
      ST_RUN: begin
        if (pd_req) state_nxt = ST_PD_ARM;
        else if (!ref_valid_r) state_nxt = ST_WAIT;
      end
      ST_PD_ARM: begin
        if (!pd_req) state_nxt = ST_RUN;
        else if (pd_cnt_r == PD_EDGES_CNT && comp_fall) begin
          state_nxt = ST_PD;
        end
      end
      ST_PD: begin
        if (!pd_req) state_nxt = ST_WAIT;
      end
      default: state_nxt = ST_OFF;
    endcase
    if (!supply_ok) state_nxt = ST_OFF;
  end

  // delay counter runs only in the delay state
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      state_r <= ST_OFF;
      dly_r   <= '0;
    end else begin
      state_r <= state_nxt;
      if (state_r == ST_DELAY && !dly_done) dly_r <= dly_r + 1'b1;
      else if (state_r != ST_DELAY) dly_r <= '0;
    end
  end

  // count complement rises seen with power down still low
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      pd_cnt_r <= 2'h0;
    end else if (state_r != ST_PD_ARM || !pd_req) begin
      pd_cnt_r <= 2'h0;
    end else if (comp_rise && pd_cnt_r != PD_EDGES_CNT) begin
      pd_cnt_r <= pd_cnt_r + 2'h1;
    end
  end

  // ===========================================================
  // output gate: opens only while true is low, closes at the
  // complement fall, so only a loss of supply or of the reference can cut a pulse short
  logic gate_r;
  wire  want_on = (state_r == ST_RUN) | (state_r == ST_PD_ARM);
  wire  gate_nxt = gate_r ? (want_on & ref_valid_r &
                            ~(state_nxt == ST_PD) & ~(state_nxt == ST_WAIT))
                          : (want_on & comp_rise);

  // gate switches only on reference edges (or a lost reference or supply)
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      gate_r <= 1'b0;
    end else begin
      gate_r <= gate_nxt;
    end
  end

  // ===========================================================
  // registered outputs
  wire osc_on = (state_r != ST_OFF) & (state_r != ST_PD);

  // outputs copy the reference cycle by cycle; no divider exists
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      diff_clock_out      <= '0;
      diff_clock_n_out    <= '0;
      osc_enable_out      <= 1'b0;
      pll_bypass_out      <= 1'b0;
      pll_wide_band_out   <= 1'b0;
      pll_narrow_band_out <= 1'b0;
      freq_100m_out       <= 1'b0;
      smbus_addr_out      <= 8'h00;
      smbus_scl_oe_n_out  <= 1'b1;
      smbus_sda_oe_n_out  <= 1'b1;
    end else begin
      diff_clock_out   <= {NUM_OUT{ref_lvl & gate_r}};
      diff_clock_n_out <= {NUM_OUT{~ref_lvl & gate_r}};
      // gate is already closed when the state reaches power down
      // oscillator waits one more cycle, until the parked outputs read low
      osc_enable_out      <= osc_on | (|diff_clock_out) | (|diff_clock_n_out);
      pll_bypass_out      <= (eff_mode == MODE_BYPASS);
      pll_wide_band_out   <= (eff_mode == MODE_WIDE);
      pll_narrow_band_out <= (eff_mode == MODE_NARROW);
      freq_100m_out       <= freq_lat_r;
      smbus_addr_out      <= addr_lat_r;
      // the block never pulls the serial lines, so it never stretches
      smbus_scl_oe_n_out  <= 1'b1;
      smbus_sda_oe_n_out  <= 1'b1;
    end
  end

  // ===========================================================
  // Avalon-MM slave: one wait cycle, read data set in that cycle
  wire [7:0] ctrl0 = {mode_lat_r, 2'h0, sw_en_r, sw_mode_r,
                      freq_lat_r};
  wire [7:0] status = {2'h0, gate_r, locked, ref_valid_r,
                       3'(state_r)};
  wire [31:0] rd_mux =
    (avs_address_in == REG_CTRL0)  ? {24'h0, ctrl0} :
    (avs_address_in == REG_STATUS) ? {24'h0, status} :
    (avs_address_in == REG_ADDR)   ? {24'h0, addr_lat_r} : 32'h0;

  // bus slave timing; unmapped addresses read zero, writes dropped
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      ack_r               <= 1'b0;
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out    <= 32'h0;
    end else begin
      ack_r               <= (avs_read_in | avs_write_in) & ~ack_r;
      avs_waitrequest_out <= ~((avs_read_in | avs_write_in) & ~ack_r);
      if (rd_take) avs_readdata_out <= rd_mux;
    end
  end


endmodule
`default_nettype wire

// ---- shared/cbp_pkg.sv ----
/*
  cbp_pkg: constants, encodings and register map for the
  clock buffer power control block.
  assumes a 10 MHz system clock and a 32-bit Avalon-MM slave.
*/
`default_nettype none
package cbp_pkg;
  // =========================================
  // timing
  localparam int unsigned SYS_CLK_HZ      = 10_000_000;
  localparam int unsigned SEQ_DELAY_MIN_US = 100;
  localparam int unsigned SEQ_DELAY_CYC   =
    (SEQ_DELAY_MIN_US * (SYS_CLK_HZ / 1_000_000) + 0) < 1 ? 1 :
    SEQ_DELAY_MIN_US * (SYS_CLK_HZ / 1_000_000);
  localparam int unsigned CNT_W           = 12;
  localparam logic [CNT_W-1:0] SEQ_DELAY_CNT = CNT_W'(SEQ_DELAY_CYC);
  localparam logic [5:0] REF_TIMEOUT_CNT  = 6'h20;
  localparam logic [1:0] PD_EDGES_CNT     = 2'h2;
  // =========================================
  // tri-level strap codes
  localparam logic [1:0] TRI_LOW  = 2'h0;
  localparam logic [1:0] TRI_MID  = 2'h1;
  localparam logic [1:0] TRI_HIGH = 2'h2;
  // =========================================
  // pll mode readback codes {bit7, bit6}
  localparam logic [1:0] MODE_NARROW = 2'h0;
  localparam logic [1:0] MODE_BYPASS = 2'h1;
  localparam logic [1:0] MODE_WIDE   = 2'h3;
  // =========================================
  // register map (byte addresses)
  localparam logic [3:0] REG_CTRL0  = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_ADDR   = 4'h8;
  // control byte 0 fields
  localparam int unsigned C0_FREQ   = 0;
  localparam int unsigned C0_SWM_LO = 1;
  localparam int unsigned C0_SWEN   = 3;
  localparam int unsigned C0_LAT_LO = 6;
  localparam logic [1:0] C0_SWM_RST = 2'h3;
  localparam logic       C0_SWEN_RST = 1'b0;
  // =========================================
  // sequencer states
  typedef enum logic [2:0] {
    ST_OFF, ST_DELAY, ST_WAIT, ST_RUN, ST_PD_ARM, ST_PD
  } cbp_state_e;
  localparam int unsigned NUM_OUT = 12;
endpackage
`default_nettype wire

// ---- test/cbp_ref_model.sv ----
/* cbp_ref_model: reference clock source and pll lock of the board.
   assumes the bench starts it only once power is good. */
`timescale 1ns/1ps
`default_nettype none
module cbp_ref_model (
  input  wire logic run_in,
  output logic      ref_clk_out,
  output logic      pll_lock_out
);
  int n_edges;
  // ==========
  // 800 ns clock of odd phase; stands low when stopped, lock needs 17 edges
  initial begin
    ref_clk_out = 1'b0;
    pll_lock_out = 1'b0;
    n_edges = 0;
    #137;
    forever begin
      #400;
      ref_clk_out = run_in ? ~ref_clk_out : 1'b0;
      n_edges = run_in ? n_edges + 1 : 0;
      pll_lock_out = (n_edges > 16);
    end
  end
endmodule
`default_nettype wire

// ---- test/cbp_top_properties.sv ----
/* cbp_top_properties: port checks of cbp_top.
   assumes one clock domain with a sync active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module cbp_top_properties
  import cbp_pkg::*;
(
  input wire logic               sys_clk_in,
  input wire logic               rst_n_in,
  input wire logic               ref_clk_in,
  input wire logic               avs_read_in,
  input wire logic               avs_write_in,
  input wire logic               avs_waitrequest_out,
  input wire logic [NUM_OUT-1:0] diff_clock_out,
  input wire logic [NUM_OUT-1:0] diff_clock_n_out,
  input wire logic               osc_enable_out,
  input wire logic               pll_bypass_out,
  input wire logic               pll_wide_band_out,
  input wire logic               pll_narrow_band_out,
  input wire logic               freq_100m_out,
  input wire logic [7:0]         smbus_addr_out,
  input wire logic               smbus_scl_oe_n_out,
  input wire logic               smbus_sda_oe_n_out
);
  default clocking dc @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  // ==========
  // any output active; idle count since the reference last moved
  wire logic [NUM_OUT-1:0] any_w = diff_clock_out | diff_clock_n_out;
  logic       ref_q_r;
  logic [6:0] idle_r;
  always_ff @(posedge sys_clk_in) begin
    ref_q_r <= ref_clk_in;
    if (!rst_n_in || ref_clk_in != ref_q_r)
      idle_r <= 7'h00;
    else if (idle_r != 7'h7f)
      idle_r <= idle_r + 7'h01;
  end
  // ==========
  // margin over the 32-cycle loss detect plus output latency
  never_both_high_a: assert property (
    (diff_clock_out & diff_clock_n_out) == '0) else $error("both rails high");
  parked_osc_off_a: assert property (
    !osc_enable_out |-> any_w == '0) else $error("outputs run with osc off");
  outputs_first_a: assert property (
    $fell(osc_enable_out) |-> $past(any_w) == '0) else $error("osc stopped first");
  no_ref_dark_a: assert property (
    idle_r >= 7'h3c |-> any_w == '0) else $error("outputs without reference");
  bus_answer_a: assert property (
    (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("no bus answer");
  answer_once_a: assert property (
    !avs_waitrequest_out |=> avs_waitrequest_out) else $error("answer too long");
  answer_cause_a: assert property (
    !avs_waitrequest_out |-> $past(avs_read_in || avs_write_in)) else $error("stray answer");
  serial_released_a: assert property (
    smbus_scl_oe_n_out && smbus_sda_oe_n_out) else $error("serial pin driven");
  straps_held_a: assert property (
    smbus_addr_out != 8'h00 |=> $stable(smbus_addr_out) && $stable(freq_100m_out))
    else $error("straps recaptured");
  mode_onehot_a: assert property (
    smbus_addr_out != 8'h00 |=> $onehot({pll_bypass_out, pll_wide_band_out,
    pll_narrow_band_out})) else $error("pll mode not one-hot");
endmodule
bind cbp_top cbp_top_properties u_cbp_top_properties (
  .sys_clk_in, .rst_n_in, .ref_clk_in, .avs_read_in, .avs_write_in, .avs_waitrequest_out,
  .diff_clock_out, .diff_clock_n_out, .osc_enable_out, .pll_bypass_out, .pll_wide_band_out,
  .pll_narrow_band_out, .freq_100m_out, .smbus_addr_out, .smbus_scl_oe_n_out,
  .smbus_sda_oe_n_out
);
`default_nettype wire

// ---- test/cbp_top_tb.sv ----
/* cbp_top_tb: self-checking bench of cbp_top.
   assumes cbp_ref_model gives the reference and the pll lock. */
`timescale 1ns/1ps
`default_nettype none
module cbp_top_tb
  import cbp_pkg::*;
;
  logic               sys_clk_in, rst_n_in, ref_clk_in, supply_good_in, power_good_in;
  logic               pll_lock_in, freq_select_strap_in, avs_read_in, avs_write_in;
  logic [1:0]         addr_strap_low_in, addr_strap_high_in, pll_bandwidth_strap_in;
  logic [3:0]         avs_address_in, avs_byteenable_in;
  logic [31:0]        avs_writedata_in, avs_readdata_out, rd;
  logic [NUM_OUT-1:0] diff_clock_out, diff_clock_n_out;
  logic               avs_waitrequest_out, osc_enable_out, pll_bypass_out, ref_run;
  logic               pll_wide_band_out, pll_narrow_band_out, freq_100m_out;
  logic [7:0]         smbus_addr_out;
  logic               smbus_scl_oe_n_out, smbus_sda_oe_n_out;
  int                 n_errors, compares, cyc;
  wire logic [2:0]    mode_w = {pll_wide_band_out, pll_bypass_out, pll_narrow_band_out};
  // ==========
  // design and reference source
  cbp_top u_cbp_top (
    .sys_clk_in, .rst_n_in, .ref_clk_in, .supply_good_in, .power_good_in, .pll_lock_in,
    .freq_select_strap_in, .addr_strap_low_in, .addr_strap_high_in, .pll_bandwidth_strap_in,
    .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in,
    .avs_readdata_out, .avs_waitrequest_out, .diff_clock_out, .diff_clock_n_out,
    .osc_enable_out, .pll_bypass_out, .pll_wide_band_out, .pll_narrow_band_out,
    .freq_100m_out, .smbus_addr_out, .smbus_scl_oe_n_out, .smbus_sda_oe_n_out);
  cbp_ref_model u_cbp_ref_model (
    .run_in(ref_run), .ref_clk_out(ref_clk_in), .pll_lock_out(pll_lock_in));
  // ==========
  // helpers
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask
  // one access; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    // only the bench timeout ends this wait
    do begin
      @(posedge sys_clk_in);
    end while (avs_waitrequest_out !== 1'b0);
    rd = avs_readdata_out;
    chk("bus answer", {31'h0, avs_waitrequest_out}, 32'h0);
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
    @(posedge sys_clk_in);
  endtask
  task automatic rchk(input string nm, input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(nm, rd, exp);
  endtask
  task automatic st(input logic [2:0] e);
    bus(1'b0, REG_STATUS, 32'h0);
    chk("state", {29'h0, rd[2:0]}, {29'h0, e});
  endtask
  task automatic do_reset();
    rst_n_in <= 1'b0;
    wait_cyc(4);
    rst_n_in <= 1'b1;
    wait_cyc(2);
  endtask
  task automatic wait_run(input int lim, output int c);
    c = 0;
    while (diff_clock_out[0] !== 1'b1 && c < lim) begin
      @(posedge sys_clk_in);
      c++;
    end
  endtask
  // ==========
  // every address and mode strap, then a second power-good rise
  task automatic t_straps();
    logic [7:0] adr [9] = '{8'hd8, 8'hda, 8'hde, 8'hc2, 8'hc4, 8'hc6, 8'hca, 8'hcc, 8'hce};
    logic [1:0] rb [3] = '{MODE_NARROW, MODE_BYPASS, MODE_WIDE};
    logic [2:0] oh [3] = '{3'h1, 3'h2, 3'h4};
    for (int i = 0; i < 9; i++) begin
      addr_strap_high_in <= 2'(i / 3);
      addr_strap_low_in <= 2'(i % 3);
      pll_bandwidth_strap_in <= 2'(i % 3);
      freq_select_strap_in <= i[0];
      power_good_in <= 1'b0;
      do_reset();
      power_good_in <= 1'b1;
      wait_cyc(10);
      chk("address", {24'h0, smbus_addr_out}, {24'h0, adr[i]});
      chk("freq", {31'h0, freq_100m_out}, {31'h0, i[0]});
      chk("mode", {29'h0, mode_w}, {29'h0, oh[i % 3]});
      rchk("ctrl0", REG_CTRL0, {24'h0, rb[i % 3], 3'h0, C0_SWM_RST, i[0]});
      addr_strap_high_in <= 2'(2 - i / 3);
      power_good_in <= 1'b0;
      wait_cyc(10);
      power_good_in <= 1'b1;
      wait_cyc(10);
      chk("held address", {24'h0, smbus_addr_out}, {24'h0, adr[i]});
    end
  endtask
  // supply, delay, wait without reference, then lock and run
  task automatic t_power_up();
    int c;
    {addr_strap_high_in, addr_strap_low_in, pll_bandwidth_strap_in} <= 6'h00;
    freq_select_strap_in <= 1'b1;
    power_good_in <= 1'b0;
    do_reset();
    supply_good_in <= 1'b1;
    wait_cyc(900);
    st(3'h1);
    power_good_in <= 1'b1;
    wait_cyc(2000);
    st(3'h2);
    chk("dark", {20'h0, diff_clock_out | diff_clock_n_out}, 32'h0);
    ref_run <= 1'b1;
    wait_run(18000, c);
    chk("lock time", 32'(c < 18000), 32'h1);
    wait_cyc(3);
    chk("complement", {20'h0, diff_clock_out ^ diff_clock_n_out}, 32'hfff);
    chk("osc on", {31'h0, osc_enable_out}, 32'h1);
    st(3'h3);
  endtask
  // each override code, release to strap, masked and unmapped writes
  task automatic t_override();
    logic [1:0] code [3] = '{2'h0, 2'h1, 2'h3};
    logic [2:0] oh [3] = '{3'h1, 3'h2, 3'h4};
    for (int k = 0; k < 3; k++) begin
      bus(1'b1, REG_CTRL0, {28'h0, 1'b1, code[k], 1'b0});
      wait_cyc(2);
      chk("sw mode", {29'h0, mode_w}, {29'h0, oh[k]});
      rchk("ctrl0", REG_CTRL0, {24'h0, MODE_NARROW, 3'h1, code[k], 1'b1});
    end
    bus(1'b1, REG_CTRL0, 32'h6);
    wait_cyc(2);
    chk("strap mode", {29'h0, mode_w}, 32'h1);
    avs_byteenable_in <= 4'h0;
    bus(1'b1, REG_CTRL0, 32'he);
    avs_byteenable_in <= 4'hf;
    rchk("masked", REG_CTRL0, {24'h0, MODE_NARROW, 3'h0, 2'h3, 1'b1});
    bus(1'b1, 4'hc, 32'hff);
    rchk("unmapped", 4'hc, 32'h0);
    // a real host would warm reset after this override
    bus(1'b1, REG_CTRL0, 32'he);
  endtask
  // power down in run, parked timing, restart
  task automatic t_power_down();
    int c;
    power_good_in <= 1'b0;
    c = 0;
    while ((diff_clock_out | diff_clock_n_out) !== '0 && c < 100) begin
      @(posedge sys_clk_in);
      c++;
    end
    chk("park time", 32'(c >= 12 && c <= 40), 32'h1);
    wait_cyc(5);
    chk("osc off", {31'h0, osc_enable_out}, 32'h0);
    st(3'h5);
    rchk("kept ctrl0", REG_CTRL0, {24'h0, MODE_NARROW, 3'h1, 2'h3, 1'b1});
    chk("released", {30'h0, smbus_scl_oe_n_out, smbus_sda_oe_n_out}, 32'h3);
    power_good_in <= 1'b1;
    wait_run(3000, c);
    chk("restart time", 32'(c < 3000), 32'h1);
    // reference lost while running: outputs go dark, back to waiting
    ref_run <= 1'b0;
    wait_cyc(80);
    chk("lost ref dark", {20'h0, diff_clock_out | diff_clock_n_out}, 32'h0);
    st(3'h2);
  endtask
  task automatic tally_and_finish();
    if (n_errors == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ==========
  // clock, hang limit and main sequence
  initial begin
    sys_clk_in = 1'b0;
    forever #50 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  initial begin
    {rst_n_in, supply_good_in, power_good_in, ref_run, avs_read_in, avs_write_in} = '0;
    {freq_select_strap_in, addr_strap_low_in, addr_strap_high_in} = '0;
    {pll_bandwidth_strap_in, avs_address_in, avs_writedata_in} = '0;
    avs_byteenable_in = 4'hf;
    {n_errors, compares, cyc} = '0;
    wait_cyc(4);
    rst_n_in <= 1'b1;
    wait_cyc(2);
    chk("idle wait", {31'h0, avs_waitrequest_out}, 32'h1);
    t_straps();
    t_power_up();
    t_override();
    t_power_down();
    tally_and_finish();
  end
endmodule
`default_nettype wire
